// File: rx_retime_pkg.sv
/*
  Shared constants and types for the receiver output retiming block.
  Assumes a 100 MHz ref_clk and a 32-bit plain register port.
*/
package rx_retime_pkg;

  // ==========================================================
  // Register map and fields
  localparam logic [3:0] STATUS_OFFS = 4'h0;
  localparam logic [3:0] IRQ_STATUS_OFFS = 4'h4;
  localparam logic [3:0] IRQ_MASK_OFFS = 4'h8;
  localparam int IRQ_W = 4;
  localparam int IRQ_SLIP_BIT = 0;
  localparam int IRQ_CODE_ERR_BIT = 1;
  localparam int IRQ_LOCK_LOST_BIT = 2;
  localparam int IRQ_LOCK_GAIN_BIT = 3;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // ==========================================================
  // Word and timing
  localparam int WORD_W = 16;
  localparam int PAY_W = WORD_W + 4;
  localparam int REF_CLK_MHZ = 100;
  localparam int LAUNCH_SETUP_NS = 20;
  localparam int SETUP_CYCLES = (LAUNCH_SETUP_NS * REF_CLK_MHZ + 999) / 1000;
  localparam logic [6:0] LOCK_GOOD_WORDS = 7'h40;
  localparam logic [1:0] LOCK_LOSS_ERRORS = 2'h2;

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    RATE_FULL = 2'b00,
    RATE_HALF = 2'b01,
    RATE_QUARTER = 2'b10,
    RATE_TEST = 2'b11
  } rate_e;

  typedef enum logic [1:0] {
    ALIGN_SEARCH = 2'b00,
    ALIGN_COUNT = 2'b01,
    ALIGN_LOCKED = 2'b10
  } align_e;

endpackage : rx_retime_pkg

// File: pin_sync.sv
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes each bit is a level; the first stage is read only by the second.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Two stages per bit, cleared by reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : pin_sync

// File: word_align_monitor.sv
/*
  Word alignment supervisor: counts clean and faulty code fields.
  Assumes word_tick pulses once per received word, code_err beside it.
*/
`timescale 1ns/1ps
module word_align_monitor
  import rx_retime_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic align_rst_n,
  input wire logic resync_disable,
  input wire logic word_tick,
  input wire logic code_err,
  output logic locked_q,
  output logic search_q
);

  align_e state_q, state_d;
  logic [6:0] good_q, good_d;
  logic [1:0] err_q, err_d;
  logic locked_d, search_d;

  // Next state of the alignment search, lock count and error run.
  always_comb begin
    state_d = state_q;
    good_d = good_q;
    err_d = err_q;
    locked_d = locked_q;
    search_d = search_q;
    if (!align_rst_n) begin
      state_d = ALIGN_SEARCH;
      good_d = 7'h00;
      err_d = 2'h0;
      locked_d = 1'b0;
      search_d = 1'b0;
    end else if (state_q == ALIGN_SEARCH) begin
      search_d = !word_tick;
      if (word_tick) begin
        state_d = ALIGN_COUNT;
        good_d = 7'h00;
        err_d = 2'h0;
      end
    end else if (word_tick && code_err) begin
      good_d = 7'h00;
      err_d = (err_q == LOCK_LOSS_ERRORS) ? err_q : err_q + 2'h1;
      if (err_q == LOCK_LOSS_ERRORS - 2'h1) begin
        locked_d = 1'b0;
        err_d = 2'h0;
        state_d = resync_disable ? ALIGN_COUNT : ALIGN_SEARCH;
      end
    end else if (word_tick) begin
      err_d = 2'h0;
      if (state_q == ALIGN_COUNT) begin
        good_d = good_q + 7'h01;
        if (good_q == LOCK_GOOD_WORDS - 7'h01) begin
          locked_d = 1'b1;
          state_d = ALIGN_LOCKED;
        end
      end
    end
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ALIGN_SEARCH;
      good_q <= 7'h00;
      err_q <= 2'h0;
      locked_q <= 1'b0;
      search_q <= 1'b0;
    end else begin
      state_q <= state_d;
      good_q <= good_d;
      err_q <= err_d;
      locked_q <= locked_d;
      search_q <= search_d;
    end
  end

  hold_reset_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      !align_rst_n |=> !locked_q && state_q == ALIGN_SEARCH)
    else $error("alignment not held in reset");
  restart_search_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      $rose(align_rst_n) && !word_tick |=> search_q)
    else $error("search not restarted after release");
  lock_count_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      $rose(locked_q) |-> $past(good_q) == LOCK_GOOD_WORDS - 7'h01)
    else $error("lock without a full clean run");
  lose_lock_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      align_rst_n && word_tick && code_err && err_q == 2'h1 && locked_q
      |=> !locked_q)
    else $error("lock kept after two errors");
  no_resync_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      align_rst_n && resync_disable && state_q != ALIGN_SEARCH
      |=> state_q != ALIGN_SEARCH)
    else $error("realigned while resync disabled");

endmodule : word_align_monitor

// File: rx_output_retiming_align.sv
/*
  Receiver output retiming and word alignment control.
  Assumes upstream word pins change on the falling edge of
  word_clock_in and are stable at its rising edge; all pins other
  than ref_clk and the register port are asynchronous to ref_clk and are synchronised here.
*/
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

// Operation
// - Retime on: launch words and status on reference clock rising edge.
// - Retime off: launch on falling edge of the true word clock.
// - Complementary word clock output is always the inverse of the true one.
// - Two rate selects pick full, half or quarter speed divider.
// - Both selects high: serial rate comes from external test clock.
// - Flag a word slip when word phase leaves the delay range.
// - Retime on: shift input level picks the applied word delay.
// - Shift output follows reference clock to word phase.
// - Shift request out is high on request in or own phase need; the code counts own phase need only with retime on.
// - Alignment reset low holds word alignment in reset.
// - Release of alignment reset restarts the alignment search.
// - Resync disable high blocks realignment on code field errors.
// - Retime on: word phase adjusted to launch cleanly on reference edge.
// - Lock only after 64 to 128 clean code fields in a row.
// - Lock drops after two consecutive code field errors.
module rx_output_retiming_align
  import rx_retime_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic local_reference_clock,
  input wire logic word_clock_in,
  input wire logic [WORD_W-1:0] word_in,
  input wire logic flag_in,
  input wire logic data_in,
  input wire logic control_in,
  input wire logic code_error_in,
  input wire logic output_retime_enable,
  input wire logic rate_select_lo,
  input wire logic rate_select_hi,
  input wire logic external_serial_test_clock,
  input wire logic delay_shift_in,
  input wire logic shift_request_in,
  input wire logic alignment_reset_n,
  input wire logic resync_disable,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic recovered_word_clock_p,
  output logic recovered_word_clock_n,
  output logic [WORD_W-1:0] word_out,
  output logic flag_bit_out,
  output logic data_word_valid,
  output logic control_word_valid,
  output logic link_locked,
  output logic word_code_error,
  output logic word_slip_out,
  output logic delay_shift_out,
  output logic shift_request_out,
  output logic serial_rate_tick,
  output logic boundary_search,
  output logic irq
);

  // ==========================================================
  // Reset release
  logic rst_meta_q, rst_n_q;

  // Reset asserts at once and releases through two stages.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // Pin synchronisers
  localparam int SYNC_W = PAY_W + 10;

  logic [SYNC_W-1:0] sync_q;
  logic wclk_s, ref_s, tst_s;
  logic retime_s, sel_lo_s, sel_hi_s;
  logic shf_in_s, srq_in_s, align_rst_s, resync_s;
  logic [PAY_W-1:0] pay_s;

  pin_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n_q),
    .d({word_clock_in, local_reference_clock, external_serial_test_clock,
        output_retime_enable, rate_select_lo, rate_select_hi,
        delay_shift_in, shift_request_in, alignment_reset_n,
        resync_disable,
        code_error_in, control_in, data_in, flag_in, word_in}),
    .q(sync_q)
  );

  // Split the synchronised group into named levels.
  assign {wclk_s, ref_s, tst_s, retime_s, sel_lo_s, sel_hi_s,
          shf_in_s, srq_in_s, align_rst_s, resync_s} = sync_q[SYNC_W-1:PAY_W];
  assign pay_s = sync_q[PAY_W-1:0];

  // ==========================================================
  // Edge finding
  logic wclk_d_q, ref_d_q, tst_d_q;
  logic wclk_rise, wclk_fall, ref_rise, tst_rise;

  // Previous samples of the synchronised clocks.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wclk_d_q <= 1'b0;
      ref_d_q <= 1'b0;
      tst_d_q <= 1'b0;
    end else begin
      wclk_d_q <= wclk_s;
      ref_d_q <= ref_s;
      tst_d_q <= tst_s;
    end
  end

  // Edge pulses, one ref_clk cycle each.
  assign wclk_rise = wclk_s & ~wclk_d_q;
  assign wclk_fall = ~wclk_s & wclk_d_q;
  assign ref_rise = ref_s & ~ref_d_q;
  assign tst_rise = tst_s & ~tst_d_q;

  // ==========================================================
  // Recovered word clock outputs
  // complementary clock pair
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      recovered_word_clock_p <= 1'b0;
      recovered_word_clock_n <= 1'b1;
    end else begin
      recovered_word_clock_p <= wclk_s;
      recovered_word_clock_n <= ~wclk_s;
    end
  end

  // ==========================================================
  // Word capture and two-word delay line
  logic [PAY_W-1:0] stage0_q, stage1_q;
  logic [1:0] seq0_q, seq1_q;

  // Each new word pushes the older one one step down the line.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stage0_q <= '0;
      stage1_q <= '0;
      seq0_q <= 2'h0;
      seq1_q <= 2'h0;
    end else if (wclk_rise) begin
      stage0_q <= pay_s;
      stage1_q <= stage0_q;
      seq0_q <= seq0_q + 2'h1;
      seq1_q <= seq0_q;
    end
  end

  // ==========================================================
  // Phase measurement and shift control
  logic [7:0] phase_q;
  logic fresh, need_shift_q;

  // Cycles since the newest word arrived, saturating.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      phase_q <= 8'h00;
    end else if (wclk_rise) begin
      phase_q <= 8'h00;
    end else if (phase_q != 8'hff) begin
      phase_q <= phase_q + 8'h01;
    end
  end

  // A word younger than the setup time is too close to the edge.
  assign fresh = phase_q < 8'(SETUP_CYCLES);

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      delay_shift_out <= 1'b0;
      need_shift_q <= 1'b0;
    end else if (ref_rise) begin
      delay_shift_out <= fresh;
      need_shift_q <= fresh != shf_in_s;
    end
  end

  // request out ors chain and own need, own need only with retime on
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shift_request_out <= 1'b0;
    end else begin
      shift_request_out <= srq_in_s | (retime_s & need_shift_q);
    end
  end

  // ==========================================================
  // Launch selection
  logic launch, slip_now, launched_q;
  logic [PAY_W-1:0] sel_pay;
  logic [1:0] sel_seq, last_seq_q;

  // delayed word keeps setup to reference edge
  assign sel_pay = (retime_s && shf_in_s) ? stage1_q : stage0_q;
  assign sel_seq = (retime_s && shf_in_s) ? seq1_q : seq0_q;
  assign launch = retime_s ? ref_rise : wclk_fall;
  assign slip_now = retime_s && launched_q && sel_seq != last_seq_q + 2'h1;

  // Launch bookkeeping for slip detection.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      launched_q <= 1'b0;
      last_seq_q <= 2'h0;
    end else if (launch) begin
      launched_q <= 1'b1;
      last_seq_q <= sel_seq;
    end
  end

  // ==========================================================
  // Word alignment
  logic locked, search;

  word_align_monitor u_align (
    .clk(ref_clk),
    .rst_n(rst_n_q),
    .align_rst_n(align_rst_s),
    .resync_disable(resync_s),
    .word_tick(wclk_rise),
    .code_err(pay_s[PAY_W-1]),
    .locked_q(locked),
    .search_q(search)
  );

  // Boundary search request to the deserialiser.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      boundary_search <= 1'b0;
    end else begin
      boundary_search <= search;
    end
  end

  // ==========================================================
  // Output launch registers
  // slip held one launch period
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      {word_code_error, control_word_valid, data_word_valid,
       flag_bit_out, word_out} <= '0;
      link_locked <= 1'b0;
      word_slip_out <= 1'b0;
    end else if (launch) begin
      {word_code_error, control_word_valid, data_word_valid,
       flag_bit_out, word_out} <= sel_pay;
      link_locked <= locked;
      word_slip_out <= slip_now;
    end
  end

  // ==========================================================
  // Rate divider
  logic [1:0] div_q;
  logic [1:0] rate_sel;
  logic tick_d;

  assign rate_sel = {sel_hi_s, sel_lo_s};

  assign tick_d = (rate_sel == RATE_FULL) ? 1'b1 :
                  (rate_sel == RATE_HALF) ? (div_q[0] == 1'b0) :
                  (rate_sel == RATE_QUARTER) ? (div_q == 2'h0) : tst_rise;

  // Free running divider and registered serial rate enable.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q <= 2'h0;
      serial_rate_tick <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      serial_rate_tick <= tick_d;
    end
  end

  // ==========================================================
  // Register port and interrupt
  logic [IRQ_W-1:0] irq_sts_q, irq_mask_q, irq_ev, irq_clr;
  logic locked_d_q;
  logic wr_sts, wr_mask;
  logic [31:0] rd_val;

  // Address decode.
  assign wr_sts = reg_write && reg_addr == IRQ_STATUS_OFFS;
  assign wr_mask = reg_write && reg_addr == IRQ_MASK_OFFS;
  assign irq_clr = wr_sts ? reg_wdata[IRQ_W-1:0] : '0;

  // Events that set sticky status bits.
  assign irq_ev[IRQ_SLIP_BIT] = launch && slip_now;
  assign irq_ev[IRQ_CODE_ERR_BIT] = wclk_rise && pay_s[PAY_W-1];
  assign irq_ev[IRQ_LOCK_LOST_BIT] = locked_d_q && !locked;
  assign irq_ev[IRQ_LOCK_GAIN_BIT] = !locked_d_q && locked;

  // Read mux; unmapped offsets read zero.
  assign rd_val = (reg_addr == STATUS_OFFS) ?
                    {28'h0, shift_request_out, delay_shift_out,
                     boundary_search, link_locked} :
                  (reg_addr == IRQ_STATUS_OFFS) ? {28'h0, irq_sts_q} :
                  (reg_addr == IRQ_MASK_OFFS) ? {28'h0, irq_mask_q} : 32'h0;

  // Sticky status, set winning over a write-one clear.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_sts_q <= '0;
      locked_d_q <= 1'b0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_ev;
      locked_d_q <= locked;
    end
  end

  // Mask, read data for one cycle, and interrupt level.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_mask_q <= IRQ_MASK_RESET;
      reg_rdata <= 32'h0;
      irq <= 1'b0;
    end else begin
      if (wr_mask) begin
        irq_mask_q <= reg_wdata[IRQ_W-1:0];
      end
      reg_rdata <= reg_read ? rd_val : 32'h0;
      irq <= |(irq_sts_q & irq_mask_q);
    end
  end

  // ==========================================================
  // Checks
  clock_inverse_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      recovered_word_clock_n == !recovered_word_clock_p)
    else $error("complementary word clock not inverted");
  retime_launch_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      retime_s && ref_rise && !shf_in_s |=> word_out == $past(stage0_q[WORD_W-1:0]))
    else $error("word not launched on reference edge");
  pass_launch_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      !retime_s && wclk_fall |=> word_out == $past(stage0_q[WORD_W-1:0]))
    else $error("word not launched on word clock fall");
  delay_pick_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      retime_s && ref_rise && shf_in_s |=> word_out == $past(stage1_q[WORD_W-1:0]))
    else $error("delayed word not selected");
  shift_phase_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      ref_rise |=> delay_shift_out == ($past(phase_q) < 8'(SETUP_CYCLES)))
    else $error("shift output does not follow phase");
  request_chain_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      srq_in_s |=> shift_request_out)
    else $error("shift request not forwarded");
  slip_flag_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      launch && slip_now |=> word_slip_out ##1 (word_slip_out || launch))
    else $error("slip not flagged for its word");
  test_clock_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      rate_sel == RATE_TEST && !tst_rise |=> !serial_rate_tick)
    else $error("serial tick without test clock edge");

endmodule : rx_output_retiming_align

// File: word_source_model.sv
/*
  Upstream deserialiser model: an 80 ns word clock and a counting word.
  Assumes the bench gives the first word and asks for code errors.
*/
`timescale 1ns/1ps
module word_source_model
  import rx_retime_pkg::*;
(
  input wire logic [WORD_W-1:0] seed_word,
  input wire logic err_req,
  output logic word_clock_in,
  output logic [WORD_W-1:0] word_in,
  output logic [WORD_W-1:0] prev_word,
  output logic code_error_in,
  output logic flag_in,
  output logic data_in,
  output logic control_in
);
  // ============================================================
  // Word attributes
  // Attributes follow the word so that the bench can predict them.
  assign flag_in = word_in[0];
  assign data_in = ~word_in[1];
  assign control_in = word_in[1];

  // ============================================================
  // Word clock and stream
  // Word and error change on the falling edge and are stable at the rise.
  initial begin
    word_clock_in = 1'b0;
    word_in = '0;
    prev_word = '0;
    code_error_in = 1'b0;
    #3;
    word_in = seed_word;
    forever begin
      word_clock_in = 1'b1;
      #40;
      word_clock_in = 1'b0;
      prev_word <= word_in;
      word_in <= word_in + 1'b1;
      code_error_in <= err_req;
      #40;
    end
  end
endmodule : word_source_model

// File: tb_rx_output_retiming_align.sv
/*
  Self-checking bench for the receiver retiming block.
  Assumes the word source model and a 100 MHz ref_clk.
*/
`timescale 1ns/1ps
module tb_rx_output_retiming_align;
  import rx_retime_pkg::*;
  logic ref_clk, nrst, local_reference_clock, word_clock_in, flag_in, data_in, control_in;
  logic code_error_in, output_retime_enable, rate_select_lo, rate_select_hi;
  logic external_serial_test_clock, delay_shift_in, shift_request_in, alignment_reset_n;
  logic resync_disable, reg_write, reg_read, recovered_word_clock_p, recovered_word_clock_n;
  logic flag_bit_out, data_word_valid, control_word_valid, link_locked, word_code_error;
  logic word_slip_out, delay_shift_out, shift_request_out, serial_rate_tick, boundary_search;
  logic irq, err_req, seen_search;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [WORD_W-1:0] word_in, word_out, prev_word, seed_word;
  int err_count, total_checks, ticks, lref_half, n, nf, nh, nq, nt;

  rx_output_retiming_align rx_output_retiming_align_inst (.ref_clk, .nrst,
    .local_reference_clock, .word_clock_in, .word_in, .flag_in, .data_in, .control_in,
    .code_error_in, .output_retime_enable, .rate_select_lo, .rate_select_hi,
    .external_serial_test_clock, .delay_shift_in, .shift_request_in, .alignment_reset_n,
    .resync_disable, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .recovered_word_clock_p, .recovered_word_clock_n, .word_out, .flag_bit_out,
    .data_word_valid, .control_word_valid, .link_locked, .word_code_error, .word_slip_out,
    .delay_shift_out, .shift_request_out, .serial_rate_tick, .boundary_search, .irq);
  word_source_model word_source_model_inst (.seed_word, .err_req, .word_clock_in, .word_in,
    .prev_word, .code_error_in, .flag_in, .data_in, .control_in);

  // ============================================================
  // Clocks and board loops
  // System clock at 100 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Reference clock rises 40 ns after the word clock; its rate can change.
  initial begin
    local_reference_clock = 1'b0;
    lref_half = 40;
    #43;
    forever begin
      local_reference_clock = ~local_reference_clock;
      #(lref_half);
    end
  end
  // Test clock unrelated to the others.
  initial begin
    external_serial_test_clock = 1'b0;
    forever #35 external_serial_test_clock = ~external_serial_test_clock;
  end
  // shift loopback: a lone receiver feeds its shift output back.
  always @(posedge ref_clk) delay_shift_in <= delay_shift_out;
  // Tick counter and search watcher.
  always @(posedge ref_clk) begin
    if (serial_rate_tick === 1'b1) ticks <= ticks + 1;
    if (boundary_search === 1'b1) seen_search <= 1'b1;
  end
  // The complementary word clock is checked every cycle.
  always @(negedge ref_clk) check({recovered_word_clock_n}, {~recovered_word_clock_p});

  // ============================================================
  // Tasks
  // Compares and counts.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : cyc
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    // Return on a rising edge so that the next stimulus follows one.
    @(posedge ref_clk);
  endtask : reg_rd
  // Holds the error request over c cycles; 8 covers one word, 16 two.
  task automatic pulse_err(input int c);
    @(posedge ref_clk);
    err_req <= 1'b1;
    cyc(c);
    err_req <= 1'b0;
  endtask : pulse_err
  task automatic rate_count(input logic [1:0] sel, output int cnt);
    @(posedge ref_clk);
    {rate_select_hi, rate_select_lo} <= sel;
    cyc(50);
    cnt = ticks;
    cyc(800);
    cnt = ticks - cnt;
  endtask : rate_count
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ============================================================
  // Main sequence
  initial begin
    {nrst, output_retime_enable, rate_select_lo, rate_select_hi, delay_shift_in} = '0;
    {shift_request_in, resync_disable, reg_write, reg_read, err_req} = '0;
    {reg_addr, reg_wdata, ticks, seen_search, err_count, total_checks} = '0;
    alignment_reset_n = 1'b1;
    void'($urandom(63801));
    seed_word = 16'($urandom());
    cyc(16);
    nrst <= 1'b1;
    cyc(8 * 56);
    check(link_locked, 1'b0);
    cyc(8 * 24);
    check(link_locked, 1'b1);
    repeat (10) begin
      @(negedge word_clock_in);
      check({recovered_word_clock_p, word_code_error, flag_bit_out, data_word_valid,
             control_word_valid, word_out},
            {1'b1, 1'b0, prev_word[0], ~prev_word[1], prev_word[1], prev_word});
    end
    reg_wr(STATUS_OFFS, 32'h0);
    reg_rd(STATUS_OFFS, rd);
    check(rd & 32'h1, 32'h1);
    reg_wr(IRQ_MASK_OFFS, 32'h1 << IRQ_CODE_ERR_BIT);
    reg_wr(IRQ_STATUS_OFFS, 32'hf);
    pulse_err(8);
    cyc(40);
    check(link_locked, 1'b1);
    check(irq, 1'b1);
    reg_rd(IRQ_STATUS_OFFS, rd);
    check(rd & (32'h1 << IRQ_CODE_ERR_BIT), 32'h1 << IRQ_CODE_ERR_BIT);
    reg_wr(IRQ_MASK_OFFS, 32'h0);
    cyc(3);
    check(irq, 1'b0);
    reg_wr(IRQ_STATUS_OFFS, 32'hf);
    reg_rd(IRQ_STATUS_OFFS, rd);
    check(rd, 32'h0);
    reg_rd(4'hc, rd);
    check(rd, 32'h0);
    shift_request_in <= 1'b1; // request from the previous receiver
    cyc($urandom_range(6, 20));
    check(shift_request_out, 1'b1);
    shift_request_in <= 1'b0;
    cyc(6);
    check(shift_request_out, 1'b0);
    seen_search <= 1'b0;
    pulse_err(16);
    cyc(40);
    check({link_locked, seen_search}, 2'b01);
    cyc(8 * 80);
    check(link_locked, 1'b1);
    alignment_reset_n <= 1'b0;
    cyc(8 * 80);
    check({link_locked, boundary_search}, 2'b00);
    alignment_reset_n <= 1'b1;
    cyc(8 * 56);
    check(link_locked, 1'b0);
    cyc(8 * 24);
    check(link_locked, 1'b1);
    resync_disable <= 1'b1;
    cyc(4);
    seen_search <= 1'b0;
    pulse_err(16);
    cyc(40);
    check({link_locked, seen_search}, 2'b00);
    resync_disable <= 1'b0; // low outside test use
    output_retime_enable <= 1'b1;
    cyc(8 * 40);
    // Reference rises with the word clock fall: the last launch holds the previous word.
    repeat (16) begin
      @(posedge local_reference_clock);
      check({word_slip_out, delay_shift_out, word_out}, {2'b00, prev_word});
    end
    reg_wr(IRQ_STATUS_OFFS, 32'hf);
    lref_half = 30;
    for (n = 0; n < 3000 && word_slip_out !== 1'b1; n++) cyc(1);
    check(word_slip_out, 1'b1);
    reg_rd(IRQ_STATUS_OFFS, rd);
    check(rd & (32'h1 << IRQ_SLIP_BIT), 32'h1 << IRQ_SLIP_BIT);
    rate_count(RATE_FULL, nf);
    rate_count(RATE_HALF, nh);
    rate_count(RATE_QUARTER, nq);
    rate_count(RATE_TEST, nt);
    check(32'(nf > 8 && nh * 2 <= nf + 4 && nh * 2 + 4 >= nf), 32'h1);
    check(32'(nq * 4 <= nf + 8 && nq * 4 + 8 >= nf), 32'h1);
    check(32'(nt >= 112 && nt <= 116), 32'h1);
    tally_and_finish();
  end

  // Cuts a hang short well beyond the expected run of about 70 us.
  initial begin
    #500000;
    err_count++;
    tally_and_finish();
  end
endmodule : tb_rx_output_retiming_align
